/* design/pls_pkg.sv */
// Shared constants and types of the power loss ride-through block
`default_nettype none

package pls_pkg;

  // Clock rate and the time bases derived from it
  localparam int unsigned CLOCK_HZ = 200_000_000;
  localparam int unsigned CENTISEC_US = 10_000;
  localparam int unsigned CYC_PER_CS = CLOCK_HZ / 1_000_000 * CENTISEC_US;
  localparam int unsigned RECOVER_HOLD_MS = 500;
  localparam int unsigned RECOVER_HOLD_CYC = CLOCK_HZ / 1_000 * RECOVER_HOLD_MS;

  // Field widths
  localparam int VOLT_W = 11;
  localparam int SPD_W = 16;
  localparam int TIME_W = 16;
  localparam int PCT_W = 14;
  localparam int ACC_W = 48;

  // Speed scaling: full scale of the setpoint is maximum speed
  localparam logic signed [SPD_W-1:0] MAX_SPEED = 16'sh7FFF;
  localparam logic [PCT_W-1:0] STEP_FULL = 14'h2710;

  // Recommended settings after power-up (volts, centiseconds, 0.01 %)
  localparam logic CFG_ENABLE_RST = 1'b0;
  localparam logic [VOLT_W-1:0] TRIP_LEVEL_RST = 11'h0F3;
  localparam logic [VOLT_W-1:0] BAND_RST = 11'h014;
  localparam logic [TIME_W-1:0] RECOV_RAMP_CS_RST = 16'h03E8;
  localparam logic [TIME_W-1:0] STOP_RAMP_CS_RST = 16'h01F4;
  localparam logic [TIME_W-1:0] MAX_DUR_CS_RST = 16'h0BB8;
  localparam logic [PCT_W-1:0] INIT_STEP_RST = 14'h0000;

  // Operating modes of the sequencer
  typedef enum logic [2:0] {
    PLS_IDLE,
    PLS_DECEL,
    PLS_PAUSE,
    PLS_RECOVER,
    PLS_TRIPPED
  } pls_mode_t;

  // Settings carried into the block as one group
  typedef struct packed {
    logic enable;
    logic [VOLT_W-1:0] trip_level;
    logic [VOLT_W-1:0] control_band;
    logic [TIME_W-1:0] recovery_ramp_duration;
    logic [TIME_W-1:0] stop_ramp_duration;
    logic [TIME_W-1:0] max_duration;
    logic [PCT_W-1:0] initial_step;
  } pls_cfg_t;

  // Whole state of the sequencer
  typedef struct packed {
    pls_mode_t mode;
    logic signed [SPD_W-1:0] setpoint;
    logic [TIME_W-1:0] timer_cs;
    logic [31:0] presc;
    logic [31:0] hold;
    logic trip;
  } pls_state_t;

  // Whole state of a ramp rate generator
  typedef struct packed {
    logic [ACC_W-1:0] acc;
  } pls_ramp_state_t;

endpackage : pls_pkg

`default_nettype wire

/* design/pls_ramp_tick.sv */
// Ramp rate generator: one-LSB step pulses spread over a duration
`default_nettype none

module pls_ramp_tick
  import pls_pkg::*;
#(
  parameter int unsigned CYC_PER_CS = pls_pkg::CYC_PER_CS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic [TIME_W-1:0] duration_cs,
  // Step pulse, one cycle per setpoint LSB
  output logic step
);

  pls_ramp_state_t cur_reg;
  pls_ramp_state_t cur_next;
  logic [ACC_W-1:0] dur_cyc;
  logic [ACC_W-1:0] acc_sum;

  // Full scale is covered in the duration: add full scale each cycle and
  // step when the duration in cycles is passed. The shortest duration is
  // far more cycles than full scale, so at most one step per cycle.
  always_comb begin
    cur_next = cur_reg;
    dur_cyc = ACC_W'((duration_cs == '0) ? 16'h0001 : duration_cs)
              * ACC_W'(CYC_PER_CS);
    acc_sum = cur_reg.acc + ACC_W'(MAX_SPEED);
    step = run && (acc_sum >= dur_cyc);
    if (!run) begin
      cur_next.acc = '0;
    end else if (step) begin
      cur_next.acc = acc_sum - dur_cyc;
    end else begin
      cur_next.acc = acc_sum;
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

endmodule : pls_ramp_tick

`default_nettype wire

/* design/pls_ride_through.sv */
// Power loss ride-through sequencer for the drive speed setpoint
`default_nettype none

module pls_ride_through
  import pls_pkg::*;
#(
  parameter int unsigned CYC_PER_CS = pls_pkg::CYC_PER_CS,
  parameter int unsigned HOLD_CYC = RECOVER_HOLD_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Settings
  input wire pls_cfg_t cfg,
  input wire logic trip_clear,
  // Measurements and demand
  input wire logic [VOLT_W-1:0] dc_link_volts,
  input wire logic signed [SPD_W-1:0] speed_demand,
  // Setpoint to the speed loop
  output logic signed [SPD_W-1:0] speed_setpoint,
  // Status
  output logic ridethrough_in_progress,
  output logic dc_link_low_trip,
  output logic coast_to_stop
);

  pls_state_t cur_reg;
  pls_state_t cur_next;
  logic active;
  logic v_low;
  logic v_high;
  logic cs_tick;
  logic timeout;
  logic dn_step;
  logic up_step;
  logic [VOLT_W:0] band_level;

  // Magnitude of a signed speed, saturated for the most negative code
  function automatic logic [SPD_W-1:0] mag(input logic signed [SPD_W-1:0] s);
    if (s == 16'sh8000) begin
      return 16'h7FFF;
    end
    return (s < 0) ? SPD_W'(-s) : SPD_W'(s);
  endfunction : mag

  // Initial reduction step in setpoint LSBs, percent clamped to full
  function automatic logic [SPD_W-1:0] step_lsb(input logic [PCT_W-1:0] pct);
    logic [31:0] p;
    p = 32'((pct > STEP_FULL) ? STEP_FULL : pct);
    return SPD_W'((p * 32'(MAX_SPEED)) / 32'(STEP_FULL));
  endfunction : step_lsb

  // Move a setpoint toward zero by amt, never past zero
  function automatic logic signed [SPD_W-1:0] shrink(
    input logic signed [SPD_W-1:0] s, input logic [SPD_W-1:0] amt);
    logic [SPD_W-1:0] m;
    m = mag(s);
    if (m <= amt) begin
      return '0;
    end
    return (s < 0) ? -$signed(m - amt) : $signed(m - amt);
  endfunction : shrink

  // Move a setpoint one LSB toward a target
  function automatic logic signed [SPD_W-1:0] toward(
    input logic signed [SPD_W-1:0] s, input logic signed [SPD_W-1:0] t);
    if (s < t) begin
      return s + 16'sh0001;
    end else if (s > t) begin
      return s - 16'sh0001;
    end
    return s;
  endfunction : toward

  // Ramp rate generators for the stop ramp and the recovery ramp
  pls_ramp_tick #(
    .CYC_PER_CS(CYC_PER_CS)
  ) u_down (
    .clock(clock),
    .rst(rst),
    .run(cur_reg.mode == PLS_DECEL),
    .duration_cs(cfg.stop_ramp_duration),
    .step(dn_step)
  );

  pls_ramp_tick #(
    .CYC_PER_CS(CYC_PER_CS)
  ) u_up (
    .clock(clock),
    .rst(rst),
    .run(cur_reg.mode == PLS_RECOVER),
    .duration_cs(cfg.recovery_ramp_duration),
    .step(up_step)
  );

  // Voltage comparisons; the band sum is one bit wider so it cannot wrap
  assign band_level = (VOLT_W + 1)'(cfg.trip_level)
                      + (VOLT_W + 1)'(cfg.control_band);
  assign v_low = dc_link_volts <= cfg.trip_level;
  assign v_high = (VOLT_W + 1)'(dc_link_volts) > band_level;
  assign active = (cur_reg.mode == PLS_DECEL) || (cur_reg.mode == PLS_PAUSE)
                  || (cur_reg.mode == PLS_RECOVER);
  assign cs_tick = cur_reg.presc == 32'(CYC_PER_CS - 1);
  assign timeout = active && (cur_reg.timer_cs >= cfg.max_duration);

  // Sequencer next state
  always_comb begin
    cur_next = cur_reg;
    // Timer counts centiseconds only while the sequence runs
    if (active && !cs_tick) begin
      cur_next.presc = cur_reg.presc + 32'h00000001;
    end else begin
      cur_next.presc = '0;
    end
    if (active && cs_tick && (cur_reg.timer_cs != 16'hFFFF)) begin
      cur_next.timer_cs = cur_reg.timer_cs + 16'h0001;
    end
    // Clear first so that a trip raised in the same cycle wins
    if (trip_clear) begin
      cur_next.trip = 1'b0;
    end
    if (timeout) begin
      // Expiry beats every other move: coast and trip
      cur_next.mode = PLS_TRIPPED;
      cur_next.setpoint = '0;
      cur_next.trip = 1'b1;
    end else begin
      unique case (cur_reg.mode)
        PLS_IDLE: begin
          cur_next.setpoint = speed_demand;
          cur_next.timer_cs = '0;
          cur_next.presc = '0;
          cur_next.hold = '0;
          if (v_low && cfg.enable) begin
            // Start with the reduction step applied
            cur_next.mode = PLS_DECEL;
            cur_next.setpoint = shrink(speed_demand,
                                       step_lsb(cfg.initial_step));
          end else if (v_low) begin
            // Disabled: undervoltage trip straight away
            cur_next.mode = PLS_TRIPPED;
            cur_next.setpoint = '0;
            cur_next.trip = 1'b1;
          end
        end
        PLS_DECEL: begin
          cur_next.hold = '0;
          if (v_high) begin
            cur_next.mode = PLS_PAUSE;
          end else if (dn_step) begin
            cur_next.setpoint = shrink(cur_reg.setpoint, 16'h0001);
          end
        end
        PLS_PAUSE: begin
          // Any dip to the band level or below restarts the 500 ms qualification
          if (!v_high) begin
            cur_next.mode = PLS_DECEL;
            cur_next.hold = '0;
          end else if (cur_reg.hold >= 32'(HOLD_CYC)) begin
            cur_next.mode = PLS_RECOVER;
          end else begin
            cur_next.hold = cur_reg.hold + 32'h00000001;
          end
        end
        PLS_RECOVER: begin
          if (v_low) begin
            // Supply lost again before recovery finished
            cur_next.mode = PLS_DECEL;
            cur_next.hold = '0;
          end else if (cur_reg.setpoint == speed_demand) begin
            cur_next.mode = PLS_IDLE;
          end else if (up_step) begin
            cur_next.setpoint = toward(cur_reg.setpoint, speed_demand);
          end
        end
        PLS_TRIPPED: begin
          // Held at zero until software clears the trip
          cur_next.setpoint = '0;
          if (trip_clear) begin
            cur_next.mode = PLS_IDLE;
          end
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur_reg.mode <= PLS_IDLE;
      cur_reg.setpoint <= '0;
      cur_reg.timer_cs <= '0;
      cur_reg.presc <= '0;
      cur_reg.hold <= '0;
      cur_reg.trip <= 1'b0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Outputs, all decoded from registered state
  assign speed_setpoint = cur_reg.setpoint;
  assign ridethrough_in_progress = active;
  assign dc_link_low_trip = cur_reg.trip;
  assign coast_to_stop = cur_reg.mode == PLS_TRIPPED;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Disabled drive trips on the next edge and never rides through
  a_off_trips: assert property (
    (cur_reg.mode == PLS_IDLE) && !cfg.enable && v_low
    |=> dc_link_low_trip && !ridethrough_in_progress && coast_to_stop)
    else $error("disabled drive did not trip on low dc link");

  // Enabled drive enters the sequence on the next edge
  a_on_starts: assert property (
    (cur_reg.mode == PLS_IDLE) && cfg.enable && v_low
    |=> ridethrough_in_progress && !coast_to_stop)
    else $error("enabled drive did not start ride-through");

  // Start applies exactly the programmed reduction step
  a_step_size: assert property (
    (cur_reg.mode == PLS_IDLE) && cfg.enable && v_low
    |=> speed_setpoint == shrink($past(speed_demand),
                                 step_lsb($past(cfg.initial_step))))
    else $error("initial reduction step wrong");

  // Stop ramp takes one LSB toward zero per rate pulse
  a_decel_step: assert property (
    (cur_reg.mode == PLS_DECEL) && dn_step && !v_high && !timeout
    |=> speed_setpoint == shrink($past(speed_setpoint), 16'h0001))
    else $error("stop ramp step wrong");

  // Stop ramp never moves away from zero
  a_decel_mono: assert property (
    (cur_reg.mode == PLS_DECEL) && !timeout
    |=> mag(speed_setpoint) <= mag($past(speed_setpoint)))
    else $error("setpoint grew during stop ramp");

  // Pause holds the setpoint still
  a_pause_hold: assert property (
    (cur_reg.mode == PLS_PAUSE) && !timeout |=> $stable(speed_setpoint))
    else $error("setpoint moved during pause");

  // Recovery only follows a full qualification above the band
  a_hold_wait: assert property (
    (cur_reg.mode == PLS_RECOVER) && ($past(cur_reg.mode) == PLS_PAUSE)
    |-> ($past(cur_reg.hold) >= 32'(HOLD_CYC)) && $past(v_high))
    else $error("recovery started before the hold time");

  // Recovery ramp moves one LSB toward the demand per rate pulse
  a_recov_step: assert property (
    (cur_reg.mode == PLS_RECOVER) && up_step && !v_low && !timeout
    && (speed_setpoint != speed_demand)
    |=> speed_setpoint == toward($past(speed_setpoint), $past(speed_demand)))
    else $error("recovery ramp step wrong");

  // Expiry coasts to zero and trips, and stays so two cycles later
  a_timeout_coast: assert property (
    timeout |=> (coast_to_stop && dc_link_low_trip
    && (speed_setpoint == 16'sh0000)) [*2])
    else $error("timeout did not coast and trip");

  // Flag rises only from an enabled low dc link
  a_flag_rise: assert property (
    $rose(ridethrough_in_progress) |-> $past(v_low && cfg.enable))
    else $error("flag rose without an enabled trigger");

  // Recovery that reaches the demand ends the sequence on the next edge
  a_recov_done: assert property (
    (cur_reg.mode == PLS_RECOVER) && !v_low && !timeout
    && (speed_setpoint == speed_demand)
    |=> !ridethrough_in_progress && !coast_to_stop)
    else $error("sequence did not end at the demand");

  // Without a low dc link an idle block stays idle
  a_no_start: assert property (
    (cur_reg.mode == PLS_IDLE) && !v_low |=> !ridethrough_in_progress)
    else $error("sequence started without a low dc link");

  // Rising above the band stops the ramp on the next edge
  a_pause_enter: assert property (
    (cur_reg.mode == PLS_DECEL) && v_high && !timeout
    |=> cur_reg.mode == PLS_PAUSE)
    else $error("stop ramp did not pause above the band");

  // A second supply loss during recovery resumes the stop ramp, no new step
  a_relapse_decel: assert property (
    (cur_reg.mode == PLS_RECOVER) && v_low && !timeout
    |=> (cur_reg.mode == PLS_DECEL) && $stable(speed_setpoint))
    else $error("low dc link during recovery not handled");

  // The trip only goes away when it is cleared
  a_trip_sticky: assert property (
    dc_link_low_trip && !trip_clear |=> dc_link_low_trip)
    else $error("undervoltage trip dropped without a clear");

endmodule : pls_ride_through

`default_nettype wire

/* dv/pls_link_model.sv */
// Dc link voltage measurement model facing the ride-through block
`default_nettype none

module pls_link_model
  import pls_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Level that supply and motor settle the link at
  input wire logic [VOLT_W-1:0] link_target,
  // Measured link, one sample late like a real converter
  output logic [VOLT_W-1:0] dc_link_volts
);
  timeunit 1ns;
  timeprecision 1ps;

  // Healthy mains during reset, so no false start at release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dc_link_volts <= 11'h226;
    end else begin
      dc_link_volts <= link_target;
    end
  end
endmodule : pls_link_model

`default_nettype wire

/* dv/tb_pls_ride_through.sv */
// Self-checking bench of the power loss ride-through sequencer
`default_nettype none

module tb_pls_ride_through
  import pls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short time bases keep the run small
  localparam int CPC = 20;
  localparam int HOLD = 50;
  logic clock = 1'b0;
  logic rst = 1'b1;
  pls_cfg_t cfg;
  logic trip_clear = 1'b0;
  logic [VOLT_W-1:0] link_target = 11'h226;
  logic [VOLT_W-1:0] dc_link_volts;
  logic signed [SPD_W-1:0] speed_demand = 16'sh0320;
  logic signed [SPD_W-1:0] speed_setpoint;
  logic ridethrough_in_progress;
  logic dc_link_low_trip;
  logic coast_to_stop;
  int n_fail = 0;
  int comparisons = 0;
  integer seed = 32'hC0BDBAEA;

  always #2.5 clock = ~clock;

  pls_link_model link_u (.clock(clock), .rst(rst),
    .link_target(link_target), .dc_link_volts(dc_link_volts));

  pls_ride_through #(.CYC_PER_CS(CPC), .HOLD_CYC(HOLD)) dut_u (
    .clock(clock), .rst(rst), .cfg(cfg), .trip_clear(trip_clear),
    .dc_link_volts(dc_link_volts), .speed_demand(speed_demand),
    .speed_setpoint(speed_setpoint),
    .ridethrough_in_progress(ridethrough_in_progress),
    .dc_link_low_trip(dc_link_low_trip), .coast_to_stop(coast_to_stop));

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // Inputs always change 1 ns after the edge, outputs have settled by then
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic chk(input logic [SPD_W-1:0] got,
                     input logic [SPD_W-1:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // The model adds one sample of delay before the block sees a level
  task automatic link(input logic [VOLT_W-1:0] v);
    link_target = v;
    tick();
  endtask : link

  function automatic int mag(input logic signed [SPD_W-1:0] v);
    return v < 0 ? -v : v;
  endfunction : mag

  // Step shrinks the magnitude and never crosses zero
  function automatic int shrink(input int d, input int pct);
    int m;
    m = mag(d[15:0]) - (pct > 10000 ? 10000 : pct) * 32767 / 10000;
    m = m < 0 ? 0 : m;
    return d < 0 ? -m : m;
  endfunction : shrink

  // One LSB per pulse; full scale takes the whole duration
  function automatic int ramp_lsb(input int n, input int dur, input int room);
    int e;
    e = n * 32767 / (dur * CPC);
    return e > room ? room : e;
  endfunction : ramp_lsb

  initial begin
    int d, p, s0, s1, e, i, md;
    // Durations times CPC stay above full scale: at most one LSB per cycle
    cfg = '{CFG_ENABLE_RST, TRIP_LEVEL_RST, BAND_RST, 16'h07D0, 16'h0BB8,
            MAX_DUR_CS_RST, INIT_STEP_RST};
    repeat (10) @(posedge clock);
    #1;
    rst = 1'b0;
    tick(2);
    chk(ridethrough_in_progress, 1'b0, "flag at reset");
    chk(speed_setpoint, speed_demand, "idle follows demand");
    $display("test reset done");
    // Disabled: low link trips and coasts, sticky until cleared
    link(cfg.trip_level);
    tick(4);
    chk(dc_link_low_trip, 1'b1, "disabled trip");
    chk(coast_to_stop, 1'b1, "disabled coast");
    chk(ridethrough_in_progress, 1'b0, "no ride when off");
    chk(speed_setpoint, 16'h0000, "coast setpoint");
    link(11'h226);
    trip_clear = 1'b1;
    tick();
    trip_clear = 1'b0;
    chk(dc_link_low_trip, 1'b0, "trip cleared");
    $display("test disabled done");
    // Full ride-through; corner steps 0 and 100 %, a negative demand
    cfg.enable = 1'b1;
    for (int k = 0; k < 4; k++) begin
      d = 400 + ($unsigned($random(seed)) % 1000);
      p = $unsigned($random(seed)) % 10500;
      p = k == 0 ? 0 : (k == 3 ? 10000 : p);
      d = k == 2 ? -d : d;
      speed_demand = d[15:0];
      cfg.initial_step = p[13:0];
      link(cfg.trip_level + 11'h001);
      tick(3);
      chk(ridethrough_in_progress, 1'b0, "start above level");
      s0 = shrink(d, p);
      link(cfg.trip_level);
      tick();
      chk(ridethrough_in_progress, 1'b1, "start at level");
      chk(speed_setpoint, s0[15:0], "initial step");
      tick(200);
      e = ramp_lsb(200, 3000, mag(s0[15:0]));
      s1 = mag(s0[15:0]) - mag(speed_setpoint) - e;
      chk(s1 inside {[-2:2]}, 1'b1, "down ramp rate");
      chk(mag(speed_setpoint) <= mag(s0[15:0]), 1'b1, "toward 0");
      // Above the band the ramp freezes; touching the band restarts it
      link(cfg.trip_level + cfg.control_band + 11'h001);
      tick(2);
      s1 = speed_setpoint;
      tick(30);
      chk(speed_setpoint, s1[15:0], "pause freezes");
      link(cfg.trip_level + cfg.control_band);
      tick(20);
      link(cfg.trip_level + cfg.control_band + 11'h001);
      tick(2);
      s1 = speed_setpoint;
      tick(HOLD - 5);
      chk(speed_setpoint, s1[15:0], "hold restarts");
      tick(10);
      s1 = speed_setpoint;
      tick(200);
      e = ramp_lsb(200, 2000, mag(d[15:0]) - mag(s1[15:0]));
      s1 = mag(speed_setpoint) - mag(s1[15:0]) - e;
      chk(s1 inside {[-2:2]}, 1'b1, "recovery ramp rate");
      if (k == 3) begin
        // Supply lost again mid-recovery: stop ramp resumes, no new step
        link(cfg.trip_level);
        tick();
        s1 = speed_setpoint;
        tick(40);
        e = mag(speed_setpoint);
        chk(ridethrough_in_progress, 1'b1, "relapse active");
        chk(e < mag(s1[15:0]), 1'b1, "relapse down");
        link(cfg.trip_level + cfg.control_band + 11'h001);
        tick(HOLD + 10);
      end
      for (i = 0; i < 8000 && ridethrough_in_progress !== 1'b0; i++) tick();
      chk(i < 8000, 1'b1, "recovery ends");
      if (i >= 8000) begin
        final_report();
      end
      chk(speed_setpoint, d[15:0], "back at demand");
    end
    $display("test ride-through done");
    // Sequence time limit, including the zero setting
    for (int k = 0; k < 2; k++) begin
      md = k * 4;
      cfg.max_duration = md[15:0];
      link(cfg.trip_level);
      tick();
      chk(ridethrough_in_progress, 1'b1, "timed start");
      for (i = 0; i < 200 && dc_link_low_trip !== 1'b1; i++) tick();
      chk(i >= md * CPC - 2 && i <= md * CPC + 3, 1'b1, "limit");
      chk(coast_to_stop, 1'b1, "limit coasts");
      chk(speed_setpoint, 16'h0000, "limit setpoint");
      chk(ridethrough_in_progress, 1'b0, "flag after limit");
      link(11'h226);
      trip_clear = 1'b1;
      tick();
      trip_clear = 1'b0;
      if (i >= 200) begin
        final_report();
      end
    end
    $display("test time limit done");
    final_report();
  end
endmodule : tb_pls_ride_through

`default_nettype wire
